// >>> core/wdt_irq_pkg.sv
// Package: register map, field positions, reset values and prescale codes.
// Assumes an 8-bit register port with one-cycle read latency.
package wdt_irq_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int NUM_SRC = 7;
  // Register offsets
  localparam logic [3:0] ADDR_WDT_PIN = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_PWM_TMR = 4'h2;
  localparam logic [3:0] ADDR_GLOBAL = 4'h3;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_PIN_STATE = 4'h5;
  // Field positions
  localparam int WDT_EN_BIT = 7;
  localparam int PIN_SEL_BIT = 6;
  localparam int PWM2_EN_BIT = 7;
  localparam int PWM1_EN_BIT = 6;
  localparam int TMR2_EN_BIT = 5;
  localparam int TMR1_EN_BIT = 4;
  localparam int TMR2_PS_LO = 2;
  localparam int TMR1_PS_LO = 0;
  localparam int GIE_BIT = 0;
  // Interrupt source bit positions in mask and flag registers
  localparam int SRC_TMR = 0;
  localparam int SRC_CHG = 1;
  localparam int SRC_EXT = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_PWM1 = 4;
  localparam int SRC_PWM2 = 5;
  localparam int SRC_CMP = 6;
  // Reset values, implemented-bit masks and unmapped read value
  localparam logic [7:0] RST_WDT_PIN = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PWM_TMR = 8'h00;
  localparam logic [7:0] MASK_IMPL = 8'h7F;
  localparam logic [7:0] WDT_PIN_IMPL = 8'hC0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Prescale codes and terminal counts (divide ratio minus one)
  localparam logic [1:0] PS_DIV2 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV32 = 2'h2;
  localparam logic [1:0] PS_DIV64 = 2'h3;
  localparam logic [5:0] PS_TERM2 = 6'h01;
  localparam logic [5:0] PS_TERM8 = 6'h07;
  localparam logic [5:0] PS_TERM32 = 6'h1F;
  localparam logic [5:0] PS_TERM64 = 6'h3F;
endpackage

// >>> core/ctl_if.sv
// Interface: control fields passed from the register file to the prescalers.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface ctl_if;
  logic tmr_en;
  logic [1:0] ps_sel;
  logic tick;
  modport ctl (output tmr_en, output ps_sel, input tick);
  modport ps (input tmr_en, input ps_sel, output tick);
endinterface

// >>> core/tmr_prescaler.sv
// Timer prescaler: emits a one-cycle tick every 2, 8, 32 or 64 clocks.
// Assumes ctl fields are registered in the same clock domain.
`timescale 1ns/1ps
module tmr_prescaler
  import wdt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  ctl_if.ps bus
);
  logic [5:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [5:0] term;

  always_comb begin
    case (bus.ps_sel)
      PS_DIV2: term = PS_TERM2;
      PS_DIV8: term = PS_TERM8;
      PS_DIV32: term = PS_TERM32;
      default: term = PS_TERM64;
    endcase
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!bus.tmr_en) begin
      cnt_d = 6'h00;
    end else if (cnt_q >= term) begin
      // Compare with >= so a ratio cut mid-count recovers at once
      cnt_d = 6'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign bus.tick = tick_q;
endmodule

// >>> core/wdt_pin_and_interrupt_mask_ctl.sv
// Control registers for watchdog enable, shared pin function, interrupt mask and PWM/timer control.
// Assumes a single-cycle register port, peripheral flag pulses on clk, async pins on the shared pins.
//
// What this block does
// - Watchdog runs only while its enable bit set
// - Select bit chooses plain input or interrupt (here it only gates the interrupt; pin data always passes)
// - Select bit zero blocks external interrupt path
// - Mask bit 7 always reads zero
// - Each source forwarded only when enabled
// - Mask bit 6 gates comparator flag
// - Mask bit 5 gates second PWM
// - Mask bit 4 gates first PWM
// - Mask bit 3 gates conversion complete
// - Mask bit 2 gates external pin flag
// - Mask bit 1 gates input change flag
// - Mask bit 0 gates timer overflow flag
// - All implemented mask bits read back
// - Second PWM off means ordinary port pin
// - Second PWM on forces pin to output
// - First PWM enable likewise controls pin
// - Prescale fields select divide 2/8/32/64
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module wdt_pin_and_interrupt_mask_ctl
  import wdt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic global_irq_on_instruction,
  input wire logic global_irq_off_instruction,
  input wire logic comparator_irq_flag,
  input wire logic second_pwm_irq_flag,
  input wire logic first_pwm_irq_flag,
  input wire logic conversion_irq_flag,
  input wire logic input_change_irq_flag,
  input wire logic timer_overflow_irq_flag,
  input wire logic shared_input_port_pin,
  input wire logic port_dir_second_pwm_in,
  input wire logic port_dir_first_pwm_in,
  output logic watchdog_run,
  output logic shared_pin_data,
  output logic irq_req,
  output logic [NUM_SRC-1:0] irq_pending_gated,
  output logic second_pwm_run,
  output logic second_pwm_pin_is_input,
  output logic first_pwm_run,
  output logic first_pwm_pin_is_input,
  output logic first_timer_tick,
  output logic second_timer_tick
);
  // ------------------------------------------
  // Pin synchroniser
  // ------------------------------------------
  // Two stages settle the pin; the third feeds the edge detector, the pin data output and the pin-state read
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic pin_s1_d, pin_s2_d, pin_s3_d;

  always_comb begin
    pin_s1_d = shared_input_port_pin;
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Idle level of an active-low interrupt line
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
    end
  end

  // ------------------------------------------
  // Register file
  // ------------------------------------------
  logic [7:0] wdt_pin_q, wdt_pin_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] pwm_tmr_q, pwm_tmr_d;
  logic gie_q, gie_d;
  logic [NUM_SRC-1:0] flag_q, flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic [NUM_SRC-1:0] src_evt;
  logic ext_fall;

  // Falling edge on the synchronised line, only when the pin is the interrupt input
  assign ext_fall = wdt_pin_q[PIN_SEL_BIT] & pin_s3_q & ~pin_s2_q;

  always_comb begin
    src_evt = '0;
    src_evt[SRC_CMP] = comparator_irq_flag;
    src_evt[SRC_PWM2] = second_pwm_irq_flag;
    src_evt[SRC_PWM1] = first_pwm_irq_flag;
    src_evt[SRC_ADC] = conversion_irq_flag;
    src_evt[SRC_EXT] = ext_fall;
    src_evt[SRC_CHG] = input_change_irq_flag;
    src_evt[SRC_TMR] = timer_overflow_irq_flag;
  end

  always_comb begin
    wdt_pin_d = wdt_pin_q;
    mask_d = mask_q;
    pwm_tmr_d = pwm_tmr_q;
    rdata_d = UNMAPPED_READ;
    if (reg_wr) begin
      if (reg_addr == ADDR_WDT_PIN) begin
        wdt_pin_d = reg_wdata & WDT_PIN_IMPL;
      end else if (reg_addr == ADDR_MASK) begin
        mask_d = reg_wdata & MASK_IMPL;
      end else if (reg_addr == ADDR_PWM_TMR) begin
        pwm_tmr_d = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_WDT_PIN) begin
        rdata_d = wdt_pin_q;
      end else if (reg_addr == ADDR_MASK) begin
        rdata_d = mask_q & MASK_IMPL;
      end else if (reg_addr == ADDR_PWM_TMR) begin
        rdata_d = pwm_tmr_q;
      end else if (reg_addr == ADDR_GLOBAL) begin
        rdata_d = {7'h00, gie_q};
      end else if (reg_addr == ADDR_FLAGS) begin
        // Pending flags read back unmasked
        rdata_d = {1'b0, flag_q};
      end else if (reg_addr == ADDR_PIN_STATE) begin
        // Pin level readable whatever the function select says
        rdata_d = {7'h00, pin_s3_q};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_pin_q <= RST_WDT_PIN;
      mask_q <= RST_MASK;
      pwm_tmr_q <= RST_PWM_TMR;
      rdata_q <= 8'h00;
    end else begin
      wdt_pin_q <= wdt_pin_d;
      mask_q <= mask_d;
      pwm_tmr_q <= pwm_tmr_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------
  // Global interrupt enable
  // ------------------------------------------
  always_comb begin
    gie_d = gie_q;
    // Instructions beat a register write, so a disable is never undone in its own cycle
    if (global_irq_off_instruction) begin
      gie_d = 1'b0;
    end else if (global_irq_on_instruction) begin
      gie_d = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_GLOBAL) begin
      gie_d = reg_wdata[GIE_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gie_q <= 1'b0;
    end else begin
      gie_q <= gie_d;
    end
  end

  // ------------------------------------------
  // Pending flags
  // ------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (reg_wr && reg_addr == ADDR_FLAGS) begin
      // Write one to clear
      flag_d = flag_q & ~reg_wdata[NUM_SRC-1:0];
    end
    // Set beats clear so no event is lost; the mask never stops a flag
    flag_d = flag_d | src_evt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ------------------------------------------
  // Interrupt gating
  // ------------------------------------------
  logic [NUM_SRC-1:0] gated;
  logic [NUM_SRC-1:0] gated_q;
  logic irq_d, irq_q;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gate_src
      // Bit g of the mask gates source g of the flag register
      assign gated[g] = flag_q[g] & mask_q[g];
    end
  endgenerate

  always_comb begin
    // Request and pending view share one stage, so they never disagree
    irq_d = gie_q & (|gated);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gated_q <= '0;
      irq_q <= 1'b0;
    end else begin
      gated_q <= gated;
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------
  // Watchdog, pin and PWM direction outputs
  // ------------------------------------------
  logic wdt_run_d, pin_data_d;
  logic pwm2_run_d, pwm2_in_d, pwm1_run_d, pwm1_in_d;
  logic wdt_run_q, pin_data_q;
  logic pwm2_run_q, pwm2_in_q, pwm1_run_q, pwm1_in_q;

  always_comb begin
    wdt_run_d = wdt_pin_q[WDT_EN_BIT];
    // Plain input data path is always available; interrupt use relies on software setting direction
    pin_data_d = pin_s3_q;
    pwm2_run_d = pwm_tmr_q[PWM2_EN_BIT];
    pwm2_in_d = pwm_tmr_q[PWM2_EN_BIT] ? 1'b0 : port_dir_second_pwm_in;
    pwm1_run_d = pwm_tmr_q[PWM1_EN_BIT];
    pwm1_in_d = pwm_tmr_q[PWM1_EN_BIT] ? 1'b0 : port_dir_first_pwm_in;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_run_q <= 1'b0;
      pin_data_q <= 1'b1;
      pwm2_run_q <= 1'b0;
      pwm2_in_q <= 1'b1;
      pwm1_run_q <= 1'b0;
      pwm1_in_q <= 1'b1;
    end else begin
      wdt_run_q <= wdt_run_d;
      pin_data_q <= pin_data_d;
      pwm2_run_q <= pwm2_run_d;
      pwm2_in_q <= pwm2_in_d;
      pwm1_run_q <= pwm1_run_d;
      pwm1_in_q <= pwm1_in_d;
    end
  end

  // ------------------------------------------
  // Timer prescalers
  // ------------------------------------------
  // Each prescaler holds at zero while its timer enable is clear
  ctl_if t1 ();
  ctl_if t2 ();

  assign t1.tmr_en = pwm_tmr_q[TMR1_EN_BIT];
  assign t1.ps_sel = pwm_tmr_q[TMR1_PS_LO+1:TMR1_PS_LO];
  assign t2.tmr_en = pwm_tmr_q[TMR2_EN_BIT];
  assign t2.ps_sel = pwm_tmr_q[TMR2_PS_LO+1:TMR2_PS_LO];

  tmr_prescaler u_ps1 (
    .clk(clk),
    .nrst(nrst),
    .bus(t1.ps)
  );

  tmr_prescaler u_ps2 (
    .clk(clk),
    .nrst(nrst),
    .bus(t2.ps)
  );

  // Every output below comes straight from a flip-flop
  assign reg_rdata = rdata_q;
  assign watchdog_run = wdt_run_q;
  assign shared_pin_data = pin_data_q;
  assign irq_req = irq_q;
  assign irq_pending_gated = gated_q;
  assign second_pwm_run = pwm2_run_q;
  assign second_pwm_pin_is_input = pwm2_in_q;
  assign first_pwm_run = pwm1_run_q;
  assign first_pwm_pin_is_input = pwm1_in_q;
  assign first_timer_tick = t1.tick;
  assign second_timer_tick = t2.tick;
endmodule

// >>> dv/wdt_irq_chk.sv
// Checker: port-level timing of the control registers and interrupt gating.
// Assumes binding to the top module; ports are picked up by name.
`timescale 1ns/1ps
module wdt_irq_chk
  import wdt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic global_irq_off_instruction,
  input wire logic port_dir_second_pwm_in,
  input wire logic port_dir_first_pwm_in,
  input wire logic watchdog_run,
  input wire logic irq_req,
  input wire logic [NUM_SRC-1:0] irq_pending_gated,
  input wire logic second_pwm_run,
  input wire logic second_pwm_pin_is_input,
  input wire logic first_pwm_run,
  input wire logic first_pwm_pin_is_input
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // A lone mask write, so the new mask holds while pending is recomputed
  sequence s_mask_wr;
    reg_wr && reg_addr == ADDR_MASK ##1 !(reg_wr && reg_addr == ADDR_MASK);
  endsequence
  property p_gate;
    s_mask_wr |=> (irq_pending_gated & ~$past(reg_wdata[NUM_SRC-1:0], 2)) == 7'h00;
  endproperty
  property p_wdt;
    reg_wr && reg_addr == ADDR_WDT_PIN |-> ##2 watchdog_run == $past(reg_wdata[WDT_EN_BIT], 2);
  endproperty
  property p_pwm_run;
    reg_wr && reg_addr == ADDR_PWM_TMR |-> ##2 second_pwm_run == $past(reg_wdata[PWM2_EN_BIT], 2)
      && first_pwm_run == $past(reg_wdata[PWM1_EN_BIT], 2);
  endproperty
  property p_mask_rd;
    reg_rd && reg_addr == ADDR_MASK |=> !reg_rdata[7];
  endproperty
  property p_pwm2_on;
    second_pwm_run |-> !second_pwm_pin_is_input;
  endproperty
  property p_pwm2_off;
    !second_pwm_run |-> second_pwm_pin_is_input == $past(port_dir_second_pwm_in);
  endproperty
  property p_pwm1_on;
    first_pwm_run |-> !first_pwm_pin_is_input;
  endproperty
  property p_pwm1_off;
    !first_pwm_run |-> first_pwm_pin_is_input == $past(port_dir_first_pwm_in);
  endproperty
  property p_req;
    irq_req |-> irq_pending_gated != 7'h00;
  endproperty
  property p_gie_off;
    global_irq_off_instruction |-> ##2 !irq_req;
  endproperty
  a_gate: assert property (p_gate) else $error("unmasked source seen");
  a_wdt: assert property (p_wdt) else $error("watchdog run wrong");
  a_pwm_run: assert property (p_pwm_run) else $error("pwm run wrong");
  a_mask_rd: assert property (p_mask_rd) else $error("mask bit 7 read high");
  a_pwm2_on: assert property (p_pwm2_on) else $error("pwm2 pin not output");
  a_pwm2_off: assert property (p_pwm2_off) else $error("pwm2 pin direction wrong");
  a_pwm1_on: assert property (p_pwm1_on) else $error("pwm1 pin not output");
  a_pwm1_off: assert property (p_pwm1_off) else $error("pwm1 pin direction wrong");
  a_req: assert property (p_req) else $error("request without source");
  a_gie_off: assert property (p_gie_off) else $error("request after disable");
endmodule

bind wdt_pin_and_interrupt_mask_ctl wdt_irq_chk u_chk (.*);

// >>> dv/irq_src_model.sv
// Model of the interrupt sources: flag pulses and the active-low pin.
// Assumes one fire bit per source, indexed as in the mask register.
`timescale 1ns/1ps
module irq_src_model
  import wdt_irq_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_SRC-1:0] fire,
  output logic comparator_irq_flag,
  output logic second_pwm_irq_flag,
  output logic first_pwm_irq_flag,
  output logic conversion_irq_flag,
  output logic input_change_irq_flag,
  output logic timer_overflow_irq_flag,
  output logic shared_input_port_pin
);
  logic [5:0] fl = 6'h00;
  logic [2:0] low_cnt = 3'h0;
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  assign {comparator_irq_flag, second_pwm_irq_flag, first_pwm_irq_flag, conversion_irq_flag} = fl[5:2];
  assign {input_change_irq_flag, timer_overflow_irq_flag} = fl[1:0];
  // Pin idles high; a request pulls it low for four clocks
  assign shared_input_port_pin = low_cnt == 3'h0;
  always @(posedge clk) begin
    fl <= {fire[6:3], fire[1:0]};
    low_cnt <= fire[SRC_EXT] ? 3'h4 : low_cnt - {2'h0, low_cnt != 3'h0};
  end
endmodule

// >>> dv/wdt_pin_and_interrupt_mask_ctl_tb.sv
// Testbench: register access, interrupt gating, pin direction and prescaler.
// Assumes the source model and the checker bound to the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module wdt_pin_and_interrupt_mask_ctl_tb;
  import wdt_irq_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [8:0] ev = 9'h000;
  logic [NUM_SRC-1:0] fire, irq_pending_gated;
  logic global_irq_on_instruction, global_irq_off_instruction, shared_input_port_pin;
  logic comparator_irq_flag, second_pwm_irq_flag, first_pwm_irq_flag, conversion_irq_flag;
  logic input_change_irq_flag, timer_overflow_irq_flag, watchdog_run, shared_pin_data, irq_req;
  logic second_pwm_run, second_pwm_pin_is_input, first_pwm_run, first_pwm_pin_is_input;
  logic first_timer_tick, second_timer_tick;
  logic port_dir_second_pwm_in = 1'b1;
  logic port_dir_first_pwm_in = 1'b1;
  logic [7:0] m;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int rt[4] = '{2, 8, 32, 64};
  assign {global_irq_off_instruction, global_irq_on_instruction, fire} = ev;
  always #5 clk = ~clk;
  wdt_pin_and_interrupt_mask_ctl dut (.*);
  irq_src_model u_src (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rck(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 9'h000;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts ticks over 128 clocks, starting at a tick, so the count is exact
  task automatic ticks(input bit sel, input int r);
    int n = 0;
    int k = 0;
    while ((sel ? second_timer_tick : first_timer_tick) !== 1'b1 && n < 70) begin
      @(posedge clk);
      #1;
      n++;
    end
    for (int i = 0; i < 128; i++) begin
      @(posedge clk);
      #1;
      if ((sel ? second_timer_tick : first_timer_tick) === 1'b1) k++;
    end
    `CHK("ticks", 128 / r, k)
  endtask
  task automatic close_out;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rck(ADDR_WDT_PIN, RST_WDT_PIN);
    rck(ADDR_MASK, RST_MASK);
    rck(ADDR_PWM_TMR, RST_PWM_TMR);
    rck(4'hF, UNMAPPED_READ);
    $display("test reset done");
    wr(ADDR_WDT_PIN, 8'hFF);
    rck(ADDR_WDT_PIN, WDT_PIN_IMPL);
    settle(3);
    `CHK("wdt", 1'b1, watchdog_run)
    wr(ADDR_WDT_PIN, 8'h40);
    settle(3);
    `CHK("wdt", 1'b0, watchdog_run)
    wr(ADDR_MASK, 8'hFF);
    rck(ADDR_MASK, MASK_IMPL);
    wr(ADDR_MASK, 8'h2A);
    rck(ADDR_MASK, 8'h2A);
    $display("test registers done");
    pulse(9'h080);
    rck(ADDR_GLOBAL, 8'h01);
    for (int k = 0; k < NUM_SRC; k++) begin
      m = 8'h01 << k;
      wr(ADDR_MASK, m);
      wr(ADDR_FLAGS, 8'h7F);
      pulse(9'h07F);
      settle(8);
      `CHK("gated", m[6:0], irq_pending_gated)
      `CHK("req", 1'b1, irq_req)
    end
    wr(ADDR_MASK, 8'h00);
    settle(3);
    `CHK("gated", 7'h00, irq_pending_gated)
    rck(ADDR_FLAGS, 8'h7F);
    wr(ADDR_WDT_PIN, 8'h00);
    wr(ADDR_FLAGS, 8'h7F);
    wr(ADDR_MASK, 8'h7F);
    pulse(9'h004);
    settle(4);
    `CHK("pin", 1'b0, shared_pin_data)
    settle(4);
    `CHK("gated", 7'h00, irq_pending_gated)
    rck(ADDR_PIN_STATE, 8'h01);
    rck(ADDR_FLAGS, 8'h00);
    pulse(9'h040);
    settle(4);
    `CHK("req", 1'b1, irq_req)
    pulse(9'h100);
    settle(3);
    `CHK("req", 1'b0, irq_req)
    `CHK("gated", 7'h40, irq_pending_gated)
    rck(ADDR_GLOBAL, 8'h00);
    $display("test interrupts done");
    wr(ADDR_PWM_TMR, 8'hC0);
    settle(3);
    `CHK("pwm", 4'hA, {second_pwm_run, second_pwm_pin_is_input, first_pwm_run, first_pwm_pin_is_input})
    @(posedge clk);
    port_dir_second_pwm_in <= 1'b0;
    wr(ADDR_PWM_TMR, 8'h00);
    settle(3);
    `CHK("pwm", 4'h1, {second_pwm_run, second_pwm_pin_is_input, first_pwm_run, first_pwm_pin_is_input})
    $display("test pwm done");
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_PWM_TMR, {4'h3, p[1:0], p[1:0]});
      settle(2);
      ticks(1'b0, rt[p]);
      ticks(1'b1, rt[p]);
    end
    $display("test prescale done");
    close_out();
  end
endmodule
